// ### rtl/fmt_map.svh
// Constants for the format command link: opcodes, CDB fields, codes and defaults
`ifndef FMT_MAP_SVH
`define FMT_MAP_SVH

// Operation codes
`define FMT_OP_FORMAT 8'h04
`define FMT_OP_REQ_SENSE 8'h03
`define FMT_OP_INQUIRY 8'h12

// Descriptor block and parameter header lengths (last byte index)
`define FMT_CDB_LAST 3'h5
`define FMT_HDR_LAST 3'h3
`define FMT_HDR_LIST 3'h4

// Descriptor byte 1 field positions
`define FMT_B1_PFS_MSB 7
`define FMT_B1_PFS_LSB 6
`define FMT_B1_LONG 5
`define FMT_B1_PDF 4
`define FMT_B1_REPL 3
`define FMT_B1_DFMT_MSB 2
`define FMT_B1_DFMT_LSB 0

// Descriptor byte 4 fast format field
`define FMT_B4_FAST_MSB 1
`define FMT_B4_FAST_LSB 0

// Defect descriptor formats
`define FMT_DFMT_BLOCK 3'h0
`define FMT_DFMT_BFI 3'h4
`define FMT_DFMT_PHYS 3'h5

// Fast format modes
`define FMT_FAST_FULL 2'h0
`define FMT_FAST_SIZE 2'h1
`define FMT_FAST_NOINIT 2'h2
`define FMT_FAST_RSVD 2'h3

// Parameter header byte 1 option bits and the value assumed without a header
`define FMT_OPT_PLD 6
`define FMT_OPT_CERT 5
`define FMT_OPT_STOP 4
`define FMT_OPT_IP 3
`define FMT_OPT_DSP 2
`define FMT_OPT_IMMED 1
`define FMT_OPT_DEFAULT 8'h30

// Status bytes
`define FMT_STS_GOOD 8'h00
`define FMT_STS_CHECK 8'h02

// Sense as {key[3:0], code[7:0], qualifier[7:0]}
`define FMT_SNS_OK 20'h00000
`define FMT_SNS_INV_CDB 20'h52400
`define FMT_SNS_FAST_COMBO 20'h52409
`define FMT_SNS_INV_OPC 20'h52000
`define FMT_SNS_FMT_BUSY 20'h20404
`define FMT_SNS_FMT_FAIL 20'h33100
`define FMT_SNS_HARD_ERR 20'h31100
`define FMT_UEC_HARD_ERR 16'hF7A7

// Block lengths
`define FMT_BLEN_512 24'h000200
`define FMT_BLEN_4096 24'h001000

`endif

// ### rtl/fmt_pkg.sv
// Types shared by both ends of the format command link
package fmt_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_RUN = 3'b100
  } dev_state_e;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_CDB = 4'b0010,
    H_WAIT = 4'b0100,
    H_OUT = 4'b1000
  } host_state_e;

  typedef logic [19:0] sense_t;

endpackage

// ### rtl/fmt_link_if.sv
// Byte link between the initiator end and the drive end
`timescale 1ns/1ps
interface fmt_link_if;
  logic cmd_valid; // Descriptor byte strobe
  logic [7:0] cmd_byte; // Descriptor byte
  logic dout_valid; // Data-out byte strobe
  logic [7:0] dout_byte; // Data-out byte
  logic xfer_rdy; // Drive asks for data-out
  logic sts_valid; // Status strobe
  logic [7:0] sts; // Status byte
  fmt_pkg::sense_t sense; // Sense key, code, qualifier

  modport dev (
    input cmd_valid, cmd_byte, dout_valid, dout_byte,
    output xfer_rdy, sts_valid, sts, sense
  );
  modport host (
    output cmd_valid, cmd_byte, dout_valid, dout_byte,
    input xfer_rdy, sts_valid, sts, sense
  );
endinterface

// ### rtl/fmt_device.sv
// Drive end: format command decoder, validator and engine launcher
// Behaviour
// - Multi-byte fields arrive most significant byte first
// - Opcode 04h selects format command decode
// - Initiator fills byte 1, long header zero
// - Data follows bit set means data-out follows
// - Without data-out, use fixed default option values
// - Replace set: drop grown list, adopt host list
// - Replace clear: keep grown list, merge host list
// - Host defect list accepted only during data-out
// - With data-out, accept descriptor formats 100b, 101b only
// - No data but nonzero format: invalid field
// - Use latest mode-select length, else previous
// - Initiator should send mode select first
// - Mode 00b: defect management and full initialize
// - Mode 01b: compatible size change only
// - Mode 01b rejects replace or nonzero list
// - After 5/24/09 initiator discards grown list first
// - 512 to 4K partial blocks become hard errors
// - Mode 10b: defect management, no initialize
// - While formatting only sense and inquiry succeed
// - Header: options byte 1, length bytes 2-3
`timescale 1ns/1ps
`include "fmt_map.svh"
module fmt_device #(
  parameter logic [23:0] DEF_BLOCK_LEN = `FMT_BLEN_512
) (
  input wire logic i_mclk, // 40 MHz clock
  input wire logic i_resetn, // Async reset, active low
  fmt_link_if.dev lnk, // Link to the initiator
  input wire logic i_ms_valid, // Mode select block length strobe
  input wire logic [23:0] i_ms_block_len, // Mode select block length
  input wire logic i_eng_done, // Engine finished, one-cycle pulse
  input wire logic i_eng_fail, // Engine failed, with done
  output logic o_eng_start, // Launch engine, one-cycle pulse
  output logic [1:0] o_fast_mode, // Fast format mode
  output logic o_init_media, // Initialize whole medium
  output logic o_replace_grown, // Drop grown list before format
  output logic [2:0] o_defect_fmt, // Defect descriptor format
  output logic [7:0] o_options, // Option bits of header byte 1
  output logic [23:0] o_block_len, // Block length to format with
  output logic o_mark_hard_err, // Mark partial 4K blocks as hard errors
  output logic o_dl_valid, // Host defect list byte strobe
  output logic [7:0] o_dl_byte, // Host defect list byte
  output logic o_formatting // Format in progress
);

  if (DEF_BLOCK_LEN == 24'h000000) begin : g_chk
    $error("fmt_device: DEF_BLOCK_LEN must be nonzero");
  end

  fmt_pkg::dev_state_e state_q, state_d;
  logic [7:0] cdb_q [0:4];
  logic [2:0] cnt_q;
  logic [2:0] hcnt_q;
  logic [7:0] len_hi_q;
  logic [15:0] rem_q;
  logic ms_valid_q;
  logic [23:0] ms_len_q;
  logic [23:0] saved_len_q;
  logic [23:0] blk_sel;
  logic done_pend_q, fail_q;
  fmt_pkg::sense_t sense_q;
  logic cdb_done, hdr_last, list_byte, list_last;
  logic [15:0] new_len;
  fmt_pkg::sense_t chk;
  logic rsp_go, rsp_chk, clr_sense, eng_go, go_data, consume, save_len;
  fmt_pkg::sense_t rsp_sense;

  // Only 4096 and its 512 emulation share a physical layout
  function automatic logic len_compat(input logic [23:0] a, input logic [23:0] b);
    len_compat = (a == b) ||
                 ((a == `FMT_BLEN_512 || a == `FMT_BLEN_4096) &&
                  (b == `FMT_BLEN_512 || b == `FMT_BLEN_4096));
  endfunction

  // Validate descriptor bytes 1 and 4; returns OK sense when legal
  function automatic fmt_pkg::sense_t cdb_check(input logic [7:0] b1, input logic [7:0] b4,
                                                input logic [23:0] nlen,
                                                input logic [23:0] clen);
    logic [2:0] df;
    logic [1:0] ff;
    logic [1:0] pfs;
    df = b1[`FMT_B1_DFMT_MSB:`FMT_B1_DFMT_LSB];
    ff = b4[`FMT_B4_FAST_MSB:`FMT_B4_FAST_LSB];
    pfs = b1[`FMT_B1_PFS_MSB:`FMT_B1_PFS_LSB];
    cdb_check = `FMT_SNS_OK;
    if (b1[`FMT_B1_LONG] || pfs == 2'h1 || ff == `FMT_FAST_RSVD) begin
      cdb_check = `FMT_SNS_INV_CDB;
    end else if (!b1[`FMT_B1_PDF] && df != `FMT_DFMT_BLOCK) begin
      cdb_check = `FMT_SNS_INV_CDB;
    end else if (b1[`FMT_B1_PDF] && df != `FMT_DFMT_BFI && df != `FMT_DFMT_PHYS) begin
      cdb_check = `FMT_SNS_INV_CDB;
    end else if (ff == `FMT_FAST_SIZE) begin
      if (pfs != 2'h0 || !len_compat(nlen, clen)) begin
        cdb_check = `FMT_SNS_INV_CDB;
      end else if (b1[`FMT_B1_REPL]) begin
        cdb_check = `FMT_SNS_FAST_COMBO;
      end
    end
  endfunction

  // Latest mode select wins, otherwise the length of the last good format
  assign blk_sel = ms_valid_q ? ms_len_q : saved_len_q;
  assign cdb_done = lnk.cmd_valid && cnt_q == `FMT_CDB_LAST;
  assign hdr_last = state_q == fmt_pkg::ST_DATA && lnk.dout_valid && hcnt_q == `FMT_HDR_LAST;
  assign list_byte = state_q == fmt_pkg::ST_DATA && lnk.dout_valid && hcnt_q == `FMT_HDR_LIST;
  assign list_last = list_byte && rem_q == 16'h0001;
  assign new_len = {len_hi_q, lnk.dout_byte};
  assign chk = cdb_check(cdb_q[1], cdb_q[4], blk_sel, saved_len_q);

  // Command decode and sequencing
  always_comb begin
    state_d = state_q;
    rsp_go = 1'b0;
    rsp_chk = 1'b0;
    rsp_sense = `FMT_SNS_OK;
    clr_sense = 1'b0;
    eng_go = 1'b0;
    go_data = 1'b0;
    consume = 1'b0;
    save_len = 1'b0;
    case (state_q)
      fmt_pkg::ST_IDLE: begin
        if (cdb_done) begin
          rsp_go = 1'b1;
          case (cdb_q[0])
            `FMT_OP_FORMAT: begin
              if (chk != `FMT_SNS_OK) begin
                rsp_chk = 1'b1;
                rsp_sense = chk;
              end else if (cdb_q[1][`FMT_B1_PDF]) begin
                rsp_go = 1'b0;
                go_data = 1'b1;
                state_d = fmt_pkg::ST_DATA;
              end else begin
                rsp_go = 1'b0;
                eng_go = 1'b1;
                state_d = fmt_pkg::ST_RUN;
              end
            end
            `FMT_OP_REQ_SENSE: begin
              rsp_sense = sense_q;
              clr_sense = 1'b1;
            end
            `FMT_OP_INQUIRY: rsp_sense = `FMT_SNS_OK;
            default: begin
              rsp_chk = 1'b1;
              rsp_sense = `FMT_SNS_INV_OPC;
            end
          endcase
        end
      end
      fmt_pkg::ST_DATA: begin
        if (hdr_last) begin
          if (o_fast_mode == `FMT_FAST_SIZE && new_len != 16'h0000) begin
            rsp_go = 1'b1;
            rsp_chk = 1'b1;
            rsp_sense = `FMT_SNS_FAST_COMBO;
            state_d = fmt_pkg::ST_IDLE;
          end else if (new_len == 16'h0000) begin
            eng_go = 1'b1;
            state_d = fmt_pkg::ST_RUN;
          end
        end else if (list_last) begin
          eng_go = 1'b1;
          state_d = fmt_pkg::ST_RUN;
        end
      end
      fmt_pkg::ST_RUN: begin
        if (cdb_done) begin
          rsp_go = 1'b1;
          rsp_chk = cdb_q[0] != `FMT_OP_REQ_SENSE && cdb_q[0] != `FMT_OP_INQUIRY;
          rsp_sense = (cdb_q[0] == `FMT_OP_INQUIRY) ? `FMT_SNS_OK : `FMT_SNS_FMT_BUSY;
        end else if (done_pend_q) begin
          rsp_go = 1'b1;
          rsp_chk = fail_q;
          rsp_sense = fail_q ? `FMT_SNS_FMT_FAIL : `FMT_SNS_OK;
          consume = 1'b1;
          save_len = !fail_q;
          state_d = fmt_pkg::ST_IDLE;
        end
      end
      default: state_d = fmt_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= fmt_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Descriptor capture; byte 5 is the control byte and is not kept
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 3'h0;
      for (int i = 0; i < 5; i++) begin
        cdb_q[i] <= 8'h00;
      end
    end else if (lnk.cmd_valid) begin
      cnt_q <= (cnt_q == `FMT_CDB_LAST) ? 3'h0 : cnt_q + 3'h1;
      if (cnt_q != `FMT_CDB_LAST) begin
        cdb_q[cnt_q] <= lnk.cmd_byte;
      end
    end
  end

  // Parameter header and host defect list intake
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hcnt_q <= 3'h0;
      len_hi_q <= 8'h00;
      rem_q <= 16'h0000;
      o_options <= `FMT_OPT_DEFAULT;
      o_dl_valid <= 1'b0;
      o_dl_byte <= 8'h00;
    end else begin
      o_dl_valid <= list_byte;
      o_dl_byte <= lnk.dout_byte;
      if (go_data) begin
        hcnt_q <= 3'h0;
      end else if (state_q == fmt_pkg::ST_DATA && lnk.dout_valid && hcnt_q != `FMT_HDR_LIST) begin
        hcnt_q <= hcnt_q + 3'h1;
      end
      if (eng_go && state_q == fmt_pkg::ST_IDLE) begin
        o_options <= `FMT_OPT_DEFAULT;
      end else if (state_q == fmt_pkg::ST_DATA && lnk.dout_valid && hcnt_q == 3'h1) begin
        o_options <= lnk.dout_byte;
      end
      if (state_q == fmt_pkg::ST_DATA && lnk.dout_valid && hcnt_q == 3'h2) begin
        len_hi_q <= lnk.dout_byte;
      end
      if (hdr_last) begin
        rem_q <= new_len;
      end else if (list_byte) begin
        rem_q <= rem_q - 16'h0001;
      end
    end
  end

  // Format request fields, latched on every descriptor completed in idle, accepted or not
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fast_mode <= `FMT_FAST_FULL;
      o_init_media <= 1'b0;
      o_replace_grown <= 1'b0;
      o_defect_fmt <= `FMT_DFMT_BLOCK;
      o_block_len <= DEF_BLOCK_LEN;
      o_mark_hard_err <= 1'b0;
      o_eng_start <= 1'b0;
      o_formatting <= 1'b0;
    end else begin
      o_eng_start <= eng_go;
      o_formatting <= state_d == fmt_pkg::ST_RUN;
      if (state_q == fmt_pkg::ST_IDLE && cdb_done) begin
        o_fast_mode <= cdb_q[4][`FMT_B4_FAST_MSB:`FMT_B4_FAST_LSB];
        // Only full mode writes the medium; mode 10b leaves it stale
        o_init_media <= cdb_q[4][`FMT_B4_FAST_MSB:`FMT_B4_FAST_LSB] == `FMT_FAST_FULL;
        o_replace_grown <= cdb_q[1][`FMT_B1_REPL];
        o_defect_fmt <= cdb_q[1][`FMT_B1_DFMT_MSB:`FMT_B1_DFMT_LSB];
        o_block_len <= blk_sel;
        o_mark_hard_err <= cdb_q[4][`FMT_B4_FAST_MSB:`FMT_B4_FAST_LSB] == `FMT_FAST_SIZE &&
                           saved_len_q == `FMT_BLEN_512 && blk_sel == `FMT_BLEN_4096;
      end
    end
  end

  // Block length memory: mode select since reset, else last good format
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ms_valid_q <= 1'b0;
      ms_len_q <= DEF_BLOCK_LEN;
      saved_len_q <= DEF_BLOCK_LEN;
    end else begin
      if (i_ms_valid) begin
        ms_valid_q <= 1'b1;
        ms_len_q <= i_ms_block_len;
      end
      if (save_len) begin
        saved_len_q <= o_block_len;
      end
    end
  end

  // Engine completion is held until a cycle free of command answers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_pend_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (i_eng_done) begin
      done_pend_q <= 1'b1;
      fail_q <= i_eng_fail;
    end else if (consume) begin
      done_pend_q <= 1'b0;
    end
  end

  // Status, stored sense and data-out request
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lnk.sts_valid <= 1'b0;
      lnk.sts <= `FMT_STS_GOOD;
      lnk.sense <= `FMT_SNS_OK;
      lnk.xfer_rdy <= 1'b0;
      sense_q <= `FMT_SNS_OK;
    end else begin
      lnk.sts_valid <= rsp_go;
      lnk.xfer_rdy <= go_data;
      if (rsp_go) begin
        lnk.sts <= rsp_chk ? `FMT_STS_CHECK : `FMT_STS_GOOD;
        lnk.sense <= rsp_sense;
      end
      if (rsp_go && rsp_chk && state_q != fmt_pkg::ST_RUN) begin
        sense_q <= rsp_sense;
      end else if (clr_sense) begin
        sense_q <= `FMT_SNS_OK;
      end
    end
  end

endmodule // fmt_device

// ### rtl/fmt_host.sv
// Initiator end: builds format descriptors, sends the header and defect list
`timescale 1ns/1ps
`include "fmt_map.svh"
module fmt_host (
  input wire logic i_mclk, // 40 MHz clock
  input wire logic i_resetn, // Async reset, active low
  fmt_link_if.host lnk, // Link to the drive
  input wire logic i_req, // Issue command, one-cycle pulse
  input wire logic [7:0] i_opcode, // Operation code
  input wire logic [1:0] i_pfs, // Protection format select
  input wire logic i_pdf, // Parameter data follows
  input wire logic i_replace, // Replace grown list
  input wire logic [2:0] i_dfmt, // Defect descriptor format
  input wire logic [1:0] i_fast_format_mode, // Fast format mode
  input wire logic [7:0] i_opts, // Header option byte
  input wire logic [15:0] i_dl_len, // Defect list length in bytes
  input wire logic [7:0] i_dl_byte, // Current defect list byte
  output logic o_dl_take, // Defect byte taken, present next
  output logic o_busy, // Command outstanding
  output logic o_refused, // Request refused, one-cycle pulse
  output logic o_done, // Status received, one-cycle pulse
  output logic [7:0] o_status, // Status byte
  output logic [19:0] o_sense, // Sense key, code, qualifier
  output logic o_need_discard // Grown list must be replaced first
);

  fmt_pkg::host_state_e state_q;
  logic [7:0] b0_q, b1_q, b4_q, opts_q;
  logic [15:0] len_q, rem_q;
  logic [2:0] idx_q;
  logic phase_q;
  logic is_fmt;

  assign is_fmt = b0_q == `FMT_OP_FORMAT;

  // Byte of the descriptor or header at a position
  function automatic logic [7:0] out_byte(input logic hdr, input logic [2:0] i);
    out_byte = 8'h00;
    if (!hdr) begin
      case (i)
        3'h0: out_byte = b0_q;
        3'h1: out_byte = b1_q;
        3'h4: out_byte = b4_q;
        default: out_byte = 8'h00;
      endcase
    end else begin
      case (i)
        3'h1: out_byte = opts_q;
        3'h2: out_byte = len_q[15:8];
        3'h3: out_byte = len_q[7:0];
        default: out_byte = 8'h00;
      endcase
    end
  endfunction

  // Sequencer and link drive
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= fmt_pkg::H_IDLE;
      {b0_q, b1_q, b4_q, opts_q} <= 32'h00000000;
      len_q <= 16'h0000;
      rem_q <= 16'h0000;
      idx_q <= 3'h0;
      phase_q <= 1'b0;
      lnk.cmd_valid <= 1'b0;
      lnk.cmd_byte <= 8'h00;
      lnk.dout_valid <= 1'b0;
      lnk.dout_byte <= 8'h00;
      o_dl_take <= 1'b0;
      o_refused <= 1'b0;
    end else begin
      lnk.cmd_valid <= 1'b0;
      lnk.dout_valid <= 1'b0;
      o_dl_take <= 1'b0;
      o_refused <= 1'b0;
      case (state_q)
        fmt_pkg::H_IDLE: begin
          if (i_req && i_opcode == `FMT_OP_FORMAT && i_fast_format_mode == `FMT_FAST_SIZE && o_need_discard) begin
            o_refused <= 1'b1;
          end else if (i_req) begin
            b0_q <= i_opcode;
            b1_q <= {i_pfs, 1'b0, i_pdf, i_replace, i_dfmt};
            b4_q <= {6'h00, i_fast_format_mode};
            opts_q <= i_opts;
            len_q <= i_dl_len;
            rem_q <= i_dl_len;
            idx_q <= 3'h0;
            state_q <= fmt_pkg::H_CDB;
          end
        end
        fmt_pkg::H_CDB: begin
          lnk.cmd_valid <= 1'b1;
          lnk.cmd_byte <= out_byte(1'b0, idx_q);
          idx_q <= (idx_q == `FMT_CDB_LAST) ? 3'h0 : idx_q + 3'h1;
          if (idx_q == `FMT_CDB_LAST) begin
            state_q <= fmt_pkg::H_WAIT;
          end
        end
        fmt_pkg::H_WAIT: begin
          if (lnk.sts_valid) begin
            state_q <= fmt_pkg::H_IDLE;
          end else if (lnk.xfer_rdy && is_fmt && b1_q[`FMT_B1_PDF]) begin
            idx_q <= 3'h0;
            phase_q <= 1'b0;
            state_q <= fmt_pkg::H_OUT;
          end
        end
        fmt_pkg::H_OUT: begin
          // Header goes out back to back; list bytes every other cycle so
          // the user has a cycle to advance after each take
          if (idx_q != `FMT_HDR_LIST) begin
            lnk.dout_valid <= 1'b1;
            lnk.dout_byte <= out_byte(1'b1, idx_q);
            idx_q <= idx_q + 3'h1;
            if (idx_q == `FMT_HDR_LAST && len_q == 16'h0000) begin
              state_q <= fmt_pkg::H_WAIT;
            end
          end else begin
            phase_q <= !phase_q;
            if (!phase_q) begin
              lnk.dout_valid <= 1'b1;
              lnk.dout_byte <= i_dl_byte;
              o_dl_take <= 1'b1;
              rem_q <= rem_q - 16'h0001;
              if (rem_q == 16'h0001) begin
                state_q <= fmt_pkg::H_WAIT;
              end
            end
          end
          if (lnk.sts_valid) begin
            state_q <= fmt_pkg::H_IDLE;
          end
        end
        default: state_q <= fmt_pkg::H_IDLE;
      endcase
    end
  end

  // Answer capture and grown list discard tracking
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_status <= `FMT_STS_GOOD;
      o_sense <= `FMT_SNS_OK;
      o_need_discard <= 1'b0;
    end else begin
      o_done <= lnk.sts_valid && state_q != fmt_pkg::H_IDLE;
      if (state_q == fmt_pkg::H_IDLE) begin
        o_busy <= i_req && !(i_opcode == `FMT_OP_FORMAT && i_fast_format_mode == `FMT_FAST_SIZE &&
                             o_need_discard);
      end else if (lnk.sts_valid) begin
        o_busy <= 1'b0;
      end
      if (lnk.sts_valid && state_q != fmt_pkg::H_IDLE) begin
        o_status <= lnk.sts;
        o_sense <= lnk.sense;
        if (is_fmt && lnk.sense == `FMT_SNS_FAST_COMBO) begin
          o_need_discard <= 1'b1;
        end else if (is_fmt && lnk.sts == `FMT_STS_GOOD && b1_q[`FMT_B1_REPL]) begin
          o_need_discard <= 1'b0;
        end
      end
    end
  end

endmodule // fmt_host

// ### dv/fmt_link_props.sv
// Checker for the format command link
`timescale 1ns/1ps
`include "fmt_map.svh"
module fmt_link_props (
  input wire logic i_mclk, // Clock
  input wire logic i_resetn, // Reset
  input wire logic cmd_valid, // Strobe
  input wire logic [7:0] cmd_byte, // Byte
  input wire logic dout_valid, // Strobe
  input wire logic [7:0] dout_byte, // Byte
  input wire logic xfer_rdy, // Request
  input wire logic sts_valid, // Strobe
  input wire logic [7:0] sts, // Status
  input wire fmt_pkg::sense_t sense // Sense
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Whole descriptor: a quiet cycle, then six back-to-back bytes
  sequence cdb_s(op_ok, b1_ok, b4_ok);
    !cmd_valid ##1 (cmd_valid && op_ok) ##1 (cmd_valid && b1_ok) ##1 cmd_valid[*2]
      ##1 (cmd_valid && b4_ok) ##1 cmd_valid;
  endsequence
  nodata_fmt_a: assert property (cdb_s(cmd_byte == 8'h04,
    !cmd_byte[4] && cmd_byte[2:0] != 3'h0, 1'b1) |=> sts_valid && sense == `FMT_SNS_INV_CDB)
    else $error("format without data not rejected");
  rsvd_fast_a: assert property (cdb_s(cmd_byte == 8'h04,
    1'b1, cmd_byte[1:0] == 2'h3) |=> sts_valid && sts == `FMT_STS_CHECK)
    else $error("reserved fast mode not rejected");
  fast_combo_a: assert property (cdb_s(cmd_byte == 8'h04,
    cmd_byte == 8'h08, cmd_byte[1:0] == 2'h1) |=> sts_valid && sense == `FMT_SNS_FAST_COMBO)
    else $error("fast size with replace not rejected");
  bad_opc_a: assert property (cdb_s(!(cmd_byte inside {8'h04, 8'h03, 8'h12}),
    1'b1, 1'b1) |=> sts_valid && sense == `FMT_SNS_INV_OPC) else $error("unknown opcode");
  rdy_cause_a: assert property (xfer_rdy |-> $past(cmd_byte[4], 5)
    && $past(cmd_byte, 6) == 8'h04) else $error("data request without data bit");
  hdr_follow_a: assert property (xfer_rdy |-> ##2 dout_valid[*4])
    else $error("header bytes not sent");
  sts_hold_a: assert property (!sts_valid |-> $stable(sts) && $stable(sense))
    else $error("status moved between answers");
  good_sense_a: assert property (sts_valid && sts == `FMT_STS_GOOD
    |-> sense inside {`FMT_SNS_OK, `FMT_SNS_FMT_BUSY}) else $error("good with bad sense");
  cover property (xfer_rdy);
  cover property (sts_valid && sts == `FMT_STS_CHECK);
  cover property (sts_valid && sts == `FMT_STS_GOOD);
endmodule // fmt_link_props

// ### dv/tb_top.sv
// Bench: initiator and drive ends joined back to back
`timescale 1ns/1ps
`include "fmt_map.svh"
module tb_top;
  logic i_mclk = 1'b0, i_resetn = 1'b0, req = 1'b0, pdf = 1'b0, repl = 1'b0, ms_v = 1'b0;
  logic eng_done = 1'b0, eng_fail = 1'b0, mark_x = 1'b0, take, busy, refd, hdone, disc;
  logic start, init_m, repl_g, mark, dl_v, fmting;
  logic [1:0] pfs = 2'h0, fast_format_mode = 2'h0, fmode;
  logic [2:0] dfmt = 3'h0, dfo;
  logic [7:0] op = 8'h00, opts = 8'h00, dl_byte = 8'h5A, xdl = 8'h5A, status, opt_o, dl_o;
  logic [15:0] dl_len = 16'h0000;
  logic [19:0] hsense;
  logic [23:0] ms_len = 24'h000000, blen, blen_x = `FMT_BLEN_512;
  int bad_count = 0, compares = 0, nd = 0, seed = 32'hB8202187;
  fmt_link_if lnk ();
  fmt_host i_fmt_host (.i_mclk(i_mclk), .i_resetn(i_resetn), .lnk(lnk.host), .i_req(req),
    .i_opcode(op), .i_pfs(pfs), .i_pdf(pdf), .i_replace(repl), .i_dfmt(dfmt), .i_fast_format_mode(fast_format_mode),
    .i_opts(opts), .i_dl_len(dl_len), .i_dl_byte(dl_byte), .o_dl_take(take), .o_busy(busy),
    .o_refused(refd), .o_done(hdone), .o_status(status), .o_sense(hsense),
    .o_need_discard(disc));
  fmt_device i_fmt_device (.i_mclk(i_mclk), .i_resetn(i_resetn), .lnk(lnk.dev),
    .i_ms_valid(ms_v), .i_ms_block_len(ms_len), .i_eng_done(eng_done), .i_eng_fail(eng_fail),
    .o_eng_start(start), .o_fast_mode(fmode), .o_init_media(init_m), .o_replace_grown(repl_g),
    .o_defect_fmt(dfo), .o_options(opt_o), .o_block_len(blen), .o_mark_hard_err(mark),
    .o_dl_valid(dl_v), .o_dl_byte(dl_o), .o_formatting(fmting));
  fmt_link_props i_fmt_link_props (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .cmd_valid(lnk.cmd_valid), .cmd_byte(lnk.cmd_byte), .dout_valid(lnk.dout_valid),
    .dout_byte(lnk.dout_byte), .xfer_rdy(lnk.xfer_rdy), .sts_valid(lnk.sts_valid),
    .sts(lnk.sts), .sense(lnk.sense));
  // 25 ns clock
  initial forever #12.5 i_mclk = ~i_mclk;
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("COUNTS compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Without data-out only a clean descriptor with a known mode may start
  function automatic logic [19:0] exp_sense(input logic [2:0] d, input logic [1:0] f);
    return (d != 3'h0 || f == `FMT_FAST_RSVD) ? `FMT_SNS_INV_CDB : `FMT_SNS_OK;
  endfunction
  task automatic msel(input logic [23:0] n);
    @(negedge i_mclk);
    ms_len = n;
    ms_v = 1'b1;
    @(negedge i_mclk);
    ms_v = 1'b0;
  endtask
  task automatic run(input logic [7:0] o, input logic [1:0] p, input logic [1:0] f,
                     input logic [2:0] d, input logic r, input logic [19:0] en);
    int k;
    k = 0;
    @(negedge i_mclk);
    op = o;
    pfs = p;
    fast_format_mode = f;
    dfmt = d;
    repl = r;
    req = 1'b1;
    @(negedge i_mclk);
    req = 1'b0;
    check("busy", busy, 1'b1);
    // Bounded wait; a hang shows up as a status mismatch
    while (hdone !== 1'b1 && k < 500) begin
      @(negedge i_mclk);
      k++;
    end
    check("status", status, en == 20'h00000 ? `FMT_STS_GOOD : `FMT_STS_CHECK);
    check("sense", hsense, en);
    check("idle", fmting, 1'b0);
    $display("TEST op %h fast %h done", o, f);
  endtask
  // List source advances on take; drive side must pass each byte in order
  always @(negedge i_mclk) begin
    if (take) dl_byte <= dl_byte + 8'h11;
    if (dl_v) begin
      check("list byte", dl_o, xdl);
      xdl = xdl + 8'h11;
      nd++;
    end
  end
  // Engine stand-in: checks launch fields, then reports done two cycles on
  always @(negedge i_mclk) if (start) begin
    check("mode", fmode, fast_format_mode);
    check("init", init_m, fast_format_mode == 2'h0);
    check("options", opt_o, pdf ? opts : `FMT_OPT_DEFAULT);
    check("replace", repl_g, repl);
    check("list fmt", dfo, dfmt);
    check("length", blen, blen_x);
    check("hard err", mark, mark_x);
    check("busy", fmting, 1'b1);
    repeat (2) @(negedge i_mclk);
    eng_done = 1'b1;
    @(negedge i_mclk);
    eng_done = 1'b0;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (8000) @(posedge i_mclk);
    bad_count++;
    report_and_stop();
  end
  // Main sequence: corners around a random sweep
  initial begin
    logic [2:0] d;
    logic [1:0] f;
    repeat (8) @(negedge i_mclk);
    i_resetn = 1'b1;
    run(8'h04, 2'h0, 2'h0, 3'h0, 1'b0, `FMT_SNS_OK);
    run(8'h04, 2'h0, 2'h3, 3'h0, 1'b0, `FMT_SNS_INV_CDB);
    run(8'hA5, 2'h0, 2'h0, 3'h0, 1'b0, `FMT_SNS_INV_OPC);
    for (int i = 0; i < 8; i++) begin
      d = 3'($random(seed));
      f = 2'($random(seed)) | 2'h2;
      run(8'h04, 2'h0, f, d, i[0], exp_sense(d, f));
    end
    msel(`FMT_BLEN_4096);
    blen_x = `FMT_BLEN_4096;
    pdf = 1'b1;
    dl_len = 16'h0003;
    opts = 8'($random(seed));
    run(8'h04, 2'h0, 2'h2, 3'h5, 1'b1, `FMT_SNS_OK);
    check("list count", nd[23:0], 24'h000003);
    pdf = 1'b0;
    dl_len = 16'h0000;
    msel(`FMT_BLEN_512);
    blen_x = `FMT_BLEN_512;
    run(8'h04, 2'h0, 2'h1, 3'h0, 1'b0, `FMT_SNS_OK);
    msel(`FMT_BLEN_4096);
    blen_x = `FMT_BLEN_4096;
    mark_x = 1'b1;
    run(8'h04, 2'h0, 2'h1, 3'h0, 1'b0, `FMT_SNS_OK);
    mark_x = 1'b0;
    run(8'h04, 2'h2, 2'h1, 3'h0, 1'b0, `FMT_SNS_INV_CDB);
    msel(`FMT_BLEN_512);
    blen_x = `FMT_BLEN_512;
    run(8'h04, 2'h0, 2'h1, 3'h0, 1'b1, `FMT_SNS_FAST_COMBO);
    check("discard", disc, 1'b1);
    // Size-only retry before the grown list is dropped must be held back
    @(negedge i_mclk);
    fast_format_mode = 2'h1;
    req = 1'b1;
    @(negedge i_mclk);
    req = 1'b0;
    check("refused", refd, 1'b1);
    check("no busy", busy, 1'b0);
    eng_fail = 1'b1;
    run(8'h04, 2'h0, 2'h0, 3'h0, 1'b1, `FMT_SNS_FMT_FAIL);
    report_and_stop();
  end
endmodule // tb_top
